/* File: logic/miwl_top.sv */
`timescale 1ns/10ps
module miwl_top
  import miwl_pkg::*;
#(
  parameter int PINS = 6,
  parameter int AW = 15
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins
  input wire logic ext_pin,
  input wire logic [PINS-1:0] port_pins,
  // Peripheral event pulses
  input wire logic [7:0] preq1_set,
  input wire logic [7:0] preq2_set,
  input wire logic [7:0] preq3_set,
  input wire logic timer0_set,
  // Core side
  input wire logic core_sleep,
  input wire logic core_int_entry,
  input wire logic core_int_return,
  input wire logic core_step_done,
  input wire logic [AW-1:0] core_return_addr,
  input wire miwl_ctx_t core_ctx,
  output logic core_wake,
  output logic core_vector,
  output logic core_restore,
  output miwl_ctx_t restore_ctx,
  output logic [AW-1:0] return_addr,
  output logic stack_reset,
  output logic regulator_low_power
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] intctl, pcflag, pcfall, pcrise, pen1, pen2, pen3;
  logic [7:0] preq1, preq2, preq3, regctl, option;
  miwl_ctx_t shadow;
  miwl_wake_t wstate;
  logic ph_valid, ph_write;
  logic [7:0] ph_addr;
  logic [AW-1:0] top_addr;
  logic [4:0] level;
  logic fault;

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  logic wr;
  logic [7:0] wd;
  assign wr = ph_valid && ph_write;
  assign wd = hwdata[7:0];

  // Zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detectors
  // ----------------------------------------------------------------
  logic [PINS:0] sync1, sync2, prev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else begin
      sync1 <= {ext_pin, port_pins};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  logic [PINS-1:0] pc_edge;
  logic ext_edge;
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      // Per-pin rising and falling detectors, both may be on
      assign pc_edge[g] = (pcrise[g] && sync2[g] && !prev[g]) ||
                          (pcfall[g] && !sync2[g] && prev[g]);
    end
  endgenerate

  // Selected edge of the external pin
  assign ext_edge = option[OPT_EDGE] ? (sync2[PINS] && !prev[PINS])
                                     : (!sync2[PINS] && prev[PINS]);

  // ----------------------------------------------------------------
  // Interrupt control register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      intctl <= RST_ZERO;
    end else begin
      if (wr && hit(ph_addr, ADDR_INTCTL)) begin
        intctl[7:1] <= wd[7:1];
      end
      if (ext_edge) begin
        intctl[IC_EXTF] <= 1'b1;
      end
      if (timer0_set) begin
        intctl[IC_T0IF] <= 1'b1;
      end
      if (core_int_entry) begin
        intctl[IC_GIE] <= 1'b0;
      end else if (core_int_return) begin
        intctl[IC_GIE] <= 1'b1;
      end
      intctl[IC_PCIF] <= |pcflag;
    end
  end

  // Per-pin flags: a detected edge wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcflag <= RST_ZERO;
    end else if (wr && hit(ph_addr, ADDR_PCFLAG)) begin
      pcflag <= {2'b00, (wd[PINS-1:0] | pc_edge)};
    end else begin
      pcflag <= {2'b00, (pcflag[PINS-1:0] | pc_edge)};
    end
  end

  // ----------------------------------------------------------------
  // Enable and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcfall <= RST_ZERO;
      pcrise <= RST_ZERO;
      pen1 <= RST_ZERO;
      pen2 <= RST_ZERO;
      pen3 <= RST_ZERO;
      option <= RST_OPTION;
      regctl <= RST_REGCTL;
    end else if (wr) begin
      if (hit(ph_addr, ADDR_PCFALL)) pcfall <= {2'b00, wd[PINS-1:0]};
      if (hit(ph_addr, ADDR_PCRISE)) pcrise <= {2'b00, wd[PINS-1:0]};
      if (hit(ph_addr, ADDR_PEN1)) pen1 <= wd;
      if (hit(ph_addr, ADDR_PEN2)) pen2 <= wd;
      if (hit(ph_addr, ADDR_PEN3)) pen3 <= wd;
      if (hit(ph_addr, ADDR_OPTION)) option <= wd;
      if (hit(ph_addr, ADDR_REGCTL)) regctl <= (wd & REG_PM_MASK) | RST_REGCTL;
    end
  end

  // Peripheral request flags: set wins over software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preq1 <= RST_ZERO;
      preq2 <= RST_ZERO;
      preq3 <= RST_ZERO;
    end else begin
      preq1 <= ((wr && hit(ph_addr, ADDR_PREQ1)) ? wd : preq1) & PREQ1_MASK | preq1_set & PREQ1_MASK;
      preq2 <= ((wr && hit(ph_addr, ADDR_PREQ2)) ? wd : preq2) | preq2_set;
      preq3 <= ((wr && hit(ph_addr, ADDR_PREQ3)) ? wd : preq3) | preq3_set;
    end
  end

  // ----------------------------------------------------------------
  // Pending request and wake sequence
  // ----------------------------------------------------------------
  logic periph_pend, pending;
  assign periph_pend = |(preq1 & pen1) || |(preq2 & pen2) || |(preq3 & pen3);
  assign pending = (intctl[IC_EXTE] && intctl[IC_EXTF]) ||
                   (intctl[IC_PCIE] && intctl[IC_PCIF]) ||
                   (intctl[IC_T0IE] && intctl[IC_T0IF]) ||
                   (intctl[IC_PERIPHERAL_IRQ_ENABLE] && periph_pend);

  // Sleep, wake, one step, then vector only with global enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wstate <= WK_RUN;
      core_wake <= 1'b0;
      core_vector <= 1'b0;
    end else begin
      core_wake <= 1'b0;
      core_vector <= 1'b0;
      unique case (wstate)
        WK_RUN: begin
          if (core_sleep) begin
            wstate <= WK_SLEEP;
          end else if (pending && intctl[IC_GIE] && !core_int_entry) begin
            core_vector <= 1'b1;
          end
        end
        WK_SLEEP: begin
          if (pending) begin
            core_wake <= 1'b1;
            wstate <= WK_STEP;
          end
        end
        WK_STEP: begin
          if (core_step_done) begin
            core_vector <= intctl[IC_GIE];
            wstate <= WK_RUN;
          end
        end
        default: wstate <= WK_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Context shadows, writable by software
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow <= '0;
    end else if (core_int_entry) begin
      shadow <= core_ctx;
      shadow.status <= core_ctx.status & STAT_SAVE_MASK;
    end else if (wr) begin
      if (hit(ph_addr, ADDR_SHW)) shadow.accum <= wd;
      if (hit(ph_addr, ADDR_SHSTAT)) shadow.status <= wd & STAT_SAVE_MASK;
      if (hit(ph_addr, ADDR_SHBANK)) shadow.bank <= wd;
      if (hit(ph_addr, ADDR_SHPTR0)) shadow.ptr0 <= hwdata[15:0];
      if (hit(ph_addr, ADDR_SHPTR1)) shadow.ptr1 <= hwdata[15:0];
      if (hit(ph_addr, ADDR_SHPAGE)) shadow.page <= wd;
    end
  end

  // Restore on return; status keeps the live timeout and power-down bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_restore <= 1'b0;
      restore_ctx <= '0;
      return_addr <= '0;
    end else begin
      core_restore <= core_int_return;
      if (core_int_return) begin
        restore_ctx <= shadow;
        restore_ctx.status <= shadow.status | (core_ctx.status & ~STAT_SAVE_MASK);
        return_addr <= top_addr;
      end
    end
  end

  miwl_stack #(.DEPTH(STACK_DEPTH), .AW(AW)) u_stack (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(core_int_entry),
    .pop(core_int_return),
    .push_addr(core_return_addr),
    .top_addr(top_addr),
    .level(level),
    .fault(fault)
  );

  // Registered status outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_reset <= 1'b0;
      regulator_low_power <= 1'b0;
    end else begin
      stack_reset <= fault;
      regulator_low_power <= regctl[1];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= 32'h0000_0000;
      if (hready && hsel && htrans[1] && !hwrite) begin
        unique case (haddr[7:0])
          ADDR_INTCTL: hrdata[7:0] <= intctl;
          ADDR_PCFLAG: hrdata[7:0] <= pcflag;
          ADDR_PCFALL: hrdata[7:0] <= pcfall;
          ADDR_PCRISE: hrdata[7:0] <= pcrise;
          ADDR_PEN1: hrdata[7:0] <= pen1;
          ADDR_PEN2: hrdata[7:0] <= pen2;
          ADDR_PEN3: hrdata[7:0] <= pen3;
          ADDR_PREQ1: hrdata[7:0] <= preq1;
          ADDR_PREQ2: hrdata[7:0] <= preq2;
          ADDR_PREQ3: hrdata[7:0] <= preq3;
          ADDR_REGCTL: hrdata[7:0] <= regctl;
          ADDR_OPTION: hrdata[7:0] <= option;
          ADDR_SHW: hrdata[7:0] <= shadow.accum;
          ADDR_SHSTAT: hrdata[7:0] <= shadow.status;
          ADDR_SHBANK: hrdata[7:0] <= shadow.bank;
          ADDR_SHPTR0: hrdata[15:0] <= shadow.ptr0;
          ADDR_SHPTR1: hrdata[15:0] <= shadow.ptr1;
          ADDR_SHPAGE: hrdata[7:0] <= shadow.page;
          ADDR_STKSTAT: hrdata[15:0] <= {SHADOW_BANK, 2'b00, fault, level};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: logic/miwl_pkg.sv */
// Summary of operation
// - Wake with global enable set vectors; otherwise execution resumes after sleep.
// - After wake, the instruction following sleep runs before any vector.
// - External pin interrupts only when its enable bit is set; edge triggered.
// - Edge select high picks rising edges, low picks falling edges.
// - Pin flag sets on each selected edge; vector needs global and pin enables.
// - Entry pushes return address, copies accumulator, status, bank, pointers, page latch.
// - Return restores saved registers from shadows, dropping changes made in the routine.
// - Shadows sit in bank 31, readable and writable, written value gets restored.
// - Return stack holds 16 entries; overflow and underflow request reset.
// - Flags set on their condition regardless of own or global enable.
// - Request one: gate, converter, receive, transmit, zeros, timer2 match, timer1 overflow.
// - Regulator mode bit: 1 low-power slow wake, 0 normal fast wake.
// - Regulator bit 0 resets and reads as 1; bits 7-2 read zero.
// - Pin-change master enable gates only the interrupt, never detection or flags.
// - Each pin has rising detector per rising register, falling per falling register.
// - Both enable bits set make a pin detect both edge directions.
// - Any pin or combination of pins may be a pin-change source.
// - Pin-change summary flag is OR of all per-pin change flags.
// - Edge during a software clear leaves the per-pin flag set.
package miwl_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INTCTL = 8'h00;
  localparam logic [7:0] ADDR_PCFLAG = 8'h04;
  localparam logic [7:0] ADDR_PCFALL = 8'h08;
  localparam logic [7:0] ADDR_PCRISE = 8'h0C;
  localparam logic [7:0] ADDR_PEN1 = 8'h10;
  localparam logic [7:0] ADDR_PEN2 = 8'h14;
  localparam logic [7:0] ADDR_PEN3 = 8'h18;
  localparam logic [7:0] ADDR_PREQ1 = 8'h1C;
  localparam logic [7:0] ADDR_PREQ2 = 8'h20;
  localparam logic [7:0] ADDR_PREQ3 = 8'h24;
  localparam logic [7:0] ADDR_REGCTL = 8'h28;
  localparam logic [7:0] ADDR_OPTION = 8'h2C;
  localparam logic [7:0] ADDR_SHW = 8'h30;
  localparam logic [7:0] ADDR_SHSTAT = 8'h34;
  localparam logic [7:0] ADDR_SHBANK = 8'h38;
  localparam logic [7:0] ADDR_SHPTR0 = 8'h3C;
  localparam logic [7:0] ADDR_SHPTR1 = 8'h40;
  localparam logic [7:0] ADDR_SHPAGE = 8'h44;
  localparam logic [7:0] ADDR_STKSTAT = 8'h48;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IC_GIE = 7;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int IC_T0IE = 5;
  localparam int IC_EXTE = 4;
  localparam int IC_PCIE = 3;
  localparam int IC_T0IF = 2;
  localparam int IC_EXTF = 1;
  localparam int IC_PCIF = 0;
  localparam int OPT_EDGE = 6;
  localparam int ST_WDT = 4;
  localparam int ST_PD = 3;
  localparam logic [7:0] PREQ1_MASK = 8'hF3;
  localparam logic [7:0] REG_PM_MASK = 8'h02;
  localparam logic [7:0] STAT_SAVE_MASK = 8'hE7;
  localparam logic [7:0] SHADOW_BANK = 8'h1F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_REGCTL = 8'h01;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam int STACK_DEPTH = 16;

  // Core context carried at interrupt entry and exit
  typedef struct packed {
    logic [7:0] accum;
    logic [7:0] status;
    logic [7:0] bank;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [7:0] page;
  } miwl_ctx_t;

  // Wake sequence states
  typedef enum logic [1:0] {
    WK_RUN = 2'b00,
    WK_SLEEP = 2'b01,
    WK_STEP = 2'b10
  } miwl_wake_t;

endpackage

/* File: logic/miwl_stack.sv */
`timescale 1ns/10ps
module miwl_stack
  import miwl_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int AW = 15
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [AW-1:0] push_addr,
  output logic [AW-1:0] top_addr,
  output logic [4:0] level,
  output logic fault
);

  logic [AW-1:0] mem [DEPTH];

  // Entry store and fill level; overflow and underflow latch a fault
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level <= 5'h00;
      fault <= 1'b0;
    end else if (push && !pop) begin
      if (level == 5'(DEPTH)) begin
        fault <= 1'b1;
      end else begin
        level <= level + 5'h01;
      end
    end else if (pop && !push) begin
      if (level == 5'h00) begin
        fault <= 1'b1;
      end else begin
        level <= level - 5'h01;
      end
    end
  end

  // Stored return addresses
  always_ff @(posedge hclk) begin
    if (push && !pop && level != 5'(DEPTH)) begin
      mem[level[3:0]] <= push_addr;
    end
  end

  // Top entry
  always_comb begin
    top_addr = (level == 5'h00) ? '0 : mem[4'(level - 5'h01)];
  end

endmodule

/* File: verification/miwl_assertions.sv */
`timescale 1ns/10ps
module miwl_assertions
  import miwl_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Core side
  input wire logic core_sleep,
  input wire logic core_step_done,
  input wire logic core_int_entry,
  input wire logic core_int_return,
  input wire logic core_wake,
  input wire logic core_vector,
  input wire logic core_restore,
  input wire logic stack_reset
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_ph;
  logic [7:0] rd_a;
  logic dormant;

  // Marks read data phases and their offset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph <= 1'b0;
      rd_a <= 8'h00;
    end else begin
      rd_ph <= hsel & hready & htrans[1] & !hwrite;
      rd_a <= haddr[7:0];
    end
  end

  // Asleep from the sleep pulse until the next instruction is done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dormant <= 1'b0;
    end else begin
      dormant <= core_sleep | (dormant & !core_step_done);
    end
  end

  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_idle_rd;
    !rd_ph |-> hrdata == 32'h0;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside data phase");
  property p_regctl;
    rd_ph && rd_a == ADDR_REGCTL |-> hrdata[0] == 1'b1 && hrdata[31:2] == 30'h0;
  endproperty
  a_regctl: assert property (p_regctl) else $error("regulator fixed bits wrong");
  property p_preq1;
    rd_ph && rd_a == ADDR_PREQ1 |-> hrdata[3:2] == 2'h0 && hrdata[31:8] == 24'h0;
  endproperty
  a_preq1: assert property (p_preq1) else $error("request one empty bits set");
  property p_wake;
    core_wake |-> dormant;
  endproperty
  a_wake: assert property (p_wake) else $error("wake while running");
  property p_step;
    dormant |-> !core_vector;
  endproperty
  a_step: assert property (p_step) else $error("vector before step done");
  property p_restore;
    core_int_return |=> core_restore;
  endproperty
  a_restore: assert property (p_restore) else $error("no restore after return");
  property p_restore_cause;
    core_restore |-> $past(core_int_return);
  endproperty
  a_restore_cause: assert property (p_restore_cause) else $error("restore without return");
  property p_sticky;
    stack_reset |=> stack_reset;
  endproperty
  a_sticky: assert property (p_sticky) else $error("stack reset dropped");
  property p_fault_cause;
    $rose(stack_reset) |-> $past(core_int_entry | core_int_return) || $past(core_int_entry | core_int_return, 2);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("stack reset without push or pop");
endmodule

bind miwl_top miwl_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .core_sleep, .core_step_done, .core_int_entry, .core_int_return, .core_wake,
  .core_vector, .core_restore, .stack_reset);

/* File: verification/miwl_core_model.sv */
`timescale 1ns/10ps
module miwl_core_model
  import miwl_pkg::*;
(
  // Clock and block requests
  input wire logic hclk,
  input wire logic core_wake,
  input wire logic core_vector,
  // Core actions
  output logic core_sleep = 1'b0,
  output logic core_int_entry = 1'b0,
  output logic core_int_return = 1'b0,
  output logic core_step_done = 1'b0,
  output logic [14:0] core_return_addr = 15'h0,
  output miwl_ctx_t core_ctx = 64'h0
);
  int step_gap = 1;
  logic in_isr = 1'b0;

  // Core action pulses, started at a clock edge
  task sleep();
    core_sleep <= 1'b1;
    @(posedge hclk);
    core_sleep <= 1'b0;
  endtask
  task enter();
    core_int_entry <= 1'b1;
    in_isr <= 1'b1;
    @(posedge hclk);
    core_int_entry <= 1'b0;
  endtask
  task leave();
    core_int_return <= 1'b1;
    in_isr <= 1'b0;
    @(posedge hclk);
    core_int_return <= 1'b0;
  endtask
  task set_ctx(input miwl_ctx_t c, input logic [14:0] ra);
    core_ctx <= c;
    core_return_addr <= ra;
  endtask

  // Runs the one instruction after sleep, promptly or slowly
  always @(posedge hclk) begin
    if (core_wake === 1'b1) begin
      repeat (step_gap) @(posedge hclk);
      core_step_done <= 1'b1;
      @(posedge hclk);
      core_step_done <= 1'b0;
    end
  end

  // Takes a vector once per routine
  always @(posedge hclk) begin
    if (core_vector === 1'b1 && !in_isr) enter();
  end
endmodule

/* File: verification/miwl_top_tb_top.sv */
`timescale 1ns/10ps
module miwl_top_tb_top
  import miwl_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, ext_pin, timer0_set;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [5:0] port_pins;
  logic [7:0] preq1_set;
  logic core_sleep, core_int_entry, core_int_return, core_step_done, core_wake, core_vector, core_restore;
  logic stack_reset, regulator_low_power;
  logic [14:0] core_return_addr, return_addr, rad;
  miwl_ctx_t core_ctx, restore_ctx, rctx, ca, cb, ce;
  int fails = 0;
  int n_checks = 0;
  int nwake = 0;
  int nvec = 0;
  int w0, v0;

  always #10 hclk = ~hclk;

  miwl_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_pin, .port_pins, .preq1_set,
    .preq2_set(8'h00), .preq3_set(8'h00), .timer0_set, .core_sleep, .core_int_entry, .core_int_return,
    .core_step_done, .core_return_addr, .core_ctx, .core_wake, .core_vector, .core_restore,
    .restore_ctx, .return_addr, .stack_reset, .regulator_low_power);
  miwl_core_model core (.hclk, .core_wake, .core_vector, .core_sleep, .core_int_entry,
    .core_int_return, .core_step_done, .core_return_addr, .core_ctx);

  // Counts pulses and keeps the restored context
  always @(posedge hclk) begin
    if (core_wake === 1'b1) nwake <= nwake + 1;
    if (core_vector === 1'b1) nvec <= nvec + 1;
    if (core_restore === 1'b1) begin
      rctx <= restore_ctx;
      rad <= return_addr;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk({32'h0, r}, {32'h0, e});
  endtask
  task automatic pin(input logic e, input logic [5:0] p);
    ext_pin <= e;
    port_pins <= p;
    wt(6);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    wt(20000);
    fails++;
    results();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, ext_pin, timer0_set, htrans, port_pins, preq1_set} = 20'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    ca = {8'h11, 8'h00, 8'h33, 16'h4455, 16'h6677, 8'h08};
    cb = {8'hEE, 8'hFF, 8'hCC, 16'hBBAA, 16'h9988, 8'h77};
    wt(12);
    hresetn <= 1'b1;
    wt(1);
    rd(ADDR_INTCTL, 32'h0);
    rd(ADDR_PREQ1, 32'h0);
    rd(ADDR_REGCTL, 32'h1);
    rd(ADDR_OPTION, 32'hFF);
    rd(8'h4C, 32'h0);
    wr(ADDR_REGCTL, 32'h3);
    rd(ADDR_REGCTL, 32'h3);
    chk({63'h0, regulator_low_power}, 64'h1);
    wr(ADDR_REGCTL, 32'hFD);
    rd(ADDR_REGCTL, 32'h1);
    chk({63'h0, regulator_low_power}, 64'h0);
    $display("test registers done");
    preq1_set <= 8'hFF;
    timer0_set <= 1'b1;
    wt(1);
    preq1_set <= 8'h00;
    timer0_set <= 1'b0;
    pin(1'b1, 6'h00);
    rd(ADDR_PREQ1, 32'hF3);
    rd(ADDR_INTCTL, 32'h6);
    chk({32'h0, nvec}, 64'h0);
    wr(ADDR_PREQ1, 32'h0);
    rd(ADDR_PREQ1, 32'h0);
    wr(ADDR_OPTION, 32'hBF);
    wr(ADDR_INTCTL, 32'h80);
    pin(1'b0, 6'h00);
    rd(ADDR_INTCTL, 32'h82);
    chk({32'h0, nvec}, 64'h0);
    wr(ADDR_INTCTL, 32'h0);
    pin(1'b1, 6'h00);
    rd(ADDR_INTCTL, 32'h0);
    wr(ADDR_OPTION, 32'hFF);
    core.set_ctx(ca, 15'h1234);
    wr(ADDR_INTCTL, 32'h90);
    pin(1'b0, 6'h00);
    chk({32'h0, nvec}, 64'h0);
    pin(1'b1, 6'h00);
    chk({63'h0, nvec != 0}, 64'h1);
    rd(ADDR_INTCTL, 32'h12);
    $display("test external pin done");
    core.set_ctx(cb, 15'h0);
    rd(ADDR_SHBANK, {24'h0, ca.bank});
    wr(ADDR_SHW, 32'h5A);
    rd(ADDR_SHW, 32'h5A);
    wr(ADDR_INTCTL, 32'h10);
    core.leave();
    wt(3);
    ce = ca;
    ce.accum = 8'h5A;
    ce.status = (ca.status & 8'hE7) | (cb.status & 8'h18);
    chk(rctx, ce);
    chk({49'h0, rad}, 64'h1234);
    rd(ADDR_INTCTL, 32'h90);
    rd(ADDR_STKSTAT, 32'h1F00);
    $display("test context done");
    wr(ADDR_INTCTL, 32'h0);
    wr(ADDR_PCRISE, 32'h05);
    wr(ADDR_PCFALL, 32'h06);
    pin(1'b1, 6'h3F);
    rd(ADDR_PCFLAG, 32'h05);
    rd(ADDR_INTCTL, 32'h1);
    wr(ADDR_PCFLAG, 32'h0);
    pin(1'b1, 6'h00);
    rd(ADDR_PCFLAG, 32'h06);
    v0 = nvec;
    wr(ADDR_INTCTL, 32'h88);
    wt(4);
    chk({63'h0, nvec != v0}, 64'h1);
    wr(ADDR_PCFLAG, 32'h0);
    wt(1); // Summary follows the flags one cycle later
    rd(ADDR_INTCTL, 32'h08);
    core.leave();
    wr(ADDR_INTCTL, 32'h0);
    $display("test pin change done");
    w0 = nwake;
    v0 = nvec;
    pin(1'b0, 6'h00);
    wr(ADDR_INTCTL, 32'h10);
    core.sleep();
    pin(1'b1, 6'h00);
    wt(4);
    chk({32'h0, nwake - w0}, 64'h1);
    chk({32'h0, nvec - v0}, 64'h0);
    core.step_gap = 3;
    wr(ADDR_INTCTL, 32'h90);
    pin(1'b0, 6'h00);
    core.sleep();
    pin(1'b1, 6'h00);
    wt(6);
    chk({32'h0, nwake - w0}, 64'h2);
    chk({63'h0, nvec != v0}, 64'h1);
    wr(ADDR_INTCTL, 32'h10);
    core.leave();
    preq1_set <= 8'h01;
    wt(1);
    preq1_set <= 8'h00;
    v0 = nvec;
    wr(ADDR_PEN1, 32'h01);
    wr(ADDR_INTCTL, 32'h80);
    wt(4);
    chk({32'h0, nvec - v0}, 64'h0);
    wr(ADDR_INTCTL, 32'hC0);
    wt(4);
    chk({63'h0, nvec != v0}, 64'h1);
    wr(ADDR_PREQ1, 32'h0);
    core.leave();
    $display("test sleep done");
    wr(ADDR_INTCTL, 32'h0);
    for (int i = 0; i < 16; i++) begin
      core.enter();
      wt(1);
    end
    rd(ADDR_STKSTAT, 32'h1F10);
    chk({63'h0, stack_reset}, 64'h0);
    core.enter();
    wt(3);
    chk({63'h0, stack_reset}, 64'h1);
    hresetn <= 1'b0;
    wt(2);
    hresetn <= 1'b1;
    wt(1);
    chk({63'h0, stack_reset}, 64'h0);
    core.leave();
    wt(3);
    chk({63'h0, stack_reset}, 64'h1);
    $display("test stack done");
    results();
  end
endmodule
